/* verilog/nand_host_pkg.sv */
// Package: constants and types for the NAND host pin controller
package nand_host_pkg;
   // Commands
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] CMD_READ_MODE = 8'h00;
   // Timing, clock 20 MHz
   localparam int CLK_HZ = 20000000;
   localparam int PWR_WAIT_US = 100;
   localparam int PWR_WAIT_CYC = PWR_WAIT_US * (CLK_HZ / 1000000);
   localparam int PROTECT_SETTLE_NS = 100;
   localparam int PROTECT_SETTLE_CYC = (PROTECT_SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int RESET_BUSY_US = 1000;
   localparam int RESET_BUSY_CYC = RESET_BUSY_US * (CLK_HZ / 1000000);
   localparam int STROBE_HALF_CYC = 1;
   localparam int CNT_W = 16;
   // Request kinds
   typedef enum logic [2:0] {
      REQ_CMD = 3'h0,
      REQ_ADDR = 3'h1,
      REQ_WDATA = 3'h2,
      REQ_RDATA = 3'h3
   } req_kind_t;
   typedef struct packed {
      req_kind_t kind;
      logic [15:0] data;
   } host_req_t;
   // Bus pin group driven by the host
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic wp_n;
   } bus_ctl_t;
   localparam bus_ctl_t CTL_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                      read_strobe_n: 1'b1, wp_n: 1'b0};
endpackage : nand_host_pkg

/* verilog/nand_host.sv */
// Host-side controller driving the asynchronous NAND pin interface
// Behaviour
// - Host drives address bits outside device space low; the code leaves this to the caller and passes the address byte as given.
// - Data input uses eight or sixteen lines by bus width.
// - Host samples at rising read strobe when read cycle time is 30ns or more.
// - After enhanced status read, issue read mode before array data; the code leaves this order to the caller.
// - Host changes write protect only when ready and outside sequences.
// - Host waits protect settle time after write protect change.
// - Host holds write protect low during power-on.
// - Host waits for ready/busy valid and high before reset.
// - Without ready/busy monitoring, wait 100us before first command.
// - Reset is first command after power-on.
// - Upper byte lines zero during command cycles on word-wide devices.
`timescale 1ns/1ps
`default_nettype none
module nand_host (
   input wire logic core_clk, // 20 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic wide_bus, // 1: sixteen-line device
   input wire logic use_rb, // 1: wait on ready/busy pin
   input wire logic req_valid, // Request present
   input wire nand_host_pkg::host_req_t req, // Request kind and data
   input wire logic wp_enable_req, // Wanted write enable level
   output logic req_ready, // Request may be taken
   output logic rsp_valid, // Read data pulse
   output logic [15:0] rsp_data, // Read data
   output logic init_done, // Power-up reset done
   output nand_host_pkg::bus_ctl_t bus_ctl, // Control pins
   output logic [15:0] io_out, // Bus lines out
   output logic io_oe, // Bus lines driven
   input wire logic [15:0] io_in, // Bus lines in
   input wire logic rb_in // Ready/busy, pulled-up open-drain wire
);
   import nand_host_pkg::*;

   // Overview of the sequencer
   // Power-up: protect held low, fixed wait, then ready/busy must read high.
   // The reset command is sent on its own, before any request is taken.
   // After reset the busy time is counted, or cut short by ready/busy.
   // Idle: a protect change wins over a waiting request, so the target
   // never sees a command inside the settle window.
   // Writes take four cycles: strobe low, strobe high, latch lines drop, idle.
   // Reads take three: strobe low, sample at the rising strobe, idle.
   // Limitation: no multi-byte bursts; every byte is one request.

   typedef enum logic [3:0] {
      ST_PWR = 4'h0, ST_RST_CMD = 4'h1, ST_RST_WAIT = 4'h2, ST_IDLE = 4'h3,
      ST_WLOW = 4'h4, ST_WHIGH = 4'h5, ST_RLOW = 4'h6, ST_RHIGH = 4'h7,
      ST_WP_SETTLE = 4'h8
   } state_t;

   // Sequencer state
   state_t state_q;
   // Shared wait counter; sized for the longest busy time
   logic [CNT_W-1:0] cnt_q;
   // Write strobe high phase counter
   logic [1:0] phase_q;
   // Reset command already on the bus
   logic rst_sent_q;
   // A command sequence is open; protect must not move
   logic in_seq_q;
   // Request being carried out
   host_req_t cur_q;

   // Address/command payload: upper lines zero, data masked on narrow parts
   function automatic logic [15:0] drive_val(input host_req_t r, input logic wide);
      if (r.kind == REQ_WDATA && wide)
         drive_val = r.data;
      else
         drive_val = {8'h00, r.data[7:0]};
   endfunction : drive_val

   // Main sequencer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_PWR;
         cnt_q <= '0;
         rst_sent_q <= 1'b0;
         in_seq_q <= 1'b0;
         cur_q <= '0;
         bus_ctl <= CTL_IDLE;
         io_out <= 16'h0000;
         io_oe <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
         init_done <= 1'b0;
         phase_q <= 2'h0;
      end else begin
         rsp_valid <= 1'b0;
         case (state_q)
            // hold protect low; fixed wait; wait on ready/busy high
            ST_PWR: begin
               bus_ctl.wp_n <= 1'b0;
               if (cnt_q != CNT_W'(PWR_WAIT_CYC))
                  cnt_q <= cnt_q + 1'b1;
               else if (!use_rb || rb_in) begin
                  cur_q <= '{kind: REQ_CMD, data: {8'h00, CMD_RESET}};
                  state_q <= ST_RST_CMD;
               end
            end
            ST_RST_CMD: begin
               rst_sent_q <= 1'b1;
               cnt_q <= '0;
               state_q <= ST_WLOW;
            end
            // wait busy time, or until ready/busy returns high
            // any busy die holds the wire low, so high means all ready
            // wire is open drain; several targets may share the pull-up
            // The first few cycles are skipped: the wire may not have fallen yet
            ST_RST_WAIT: begin
               if (cnt_q != CNT_W'(RESET_BUSY_CYC) && !(use_rb && rb_in && cnt_q > 16'h0004))
                  cnt_q <= cnt_q + 1'b1;
               else begin
                  init_done <= 1'b1;
                  req_ready <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               bus_ctl.ce_n <= 1'b1;
               io_oe <= 1'b0;
               // change protect only when idle and ready; settle after
               // protect low keeps program and erase refused by the target
               // protect pin is driven even while chip select is high
               if (wp_enable_req != bus_ctl.wp_n && !in_seq_q && (!use_rb || rb_in)) begin
                  bus_ctl.wp_n <= wp_enable_req;
                  cnt_q <= '0;
                  req_ready <= 1'b0;
                  state_q <= ST_WP_SETTLE;
               end else if (req_valid) begin
                  cur_q <= req;
                  req_ready <= 1'b0;
                  cnt_q <= '0;
                  // A command opens a sequence; a read ends it
                  in_seq_q <= (req.kind != REQ_RDATA);
                  state_q <= (req.kind == REQ_RDATA) ? ST_RLOW : ST_WLOW;
               end
            end
            // Protect settle: no command until the count runs out
            ST_WP_SETTLE: begin
               if (cnt_q != CNT_W'(PROTECT_SETTLE_CYC))
                  cnt_q <= cnt_q + 1'b1;
               else begin
                  req_ready <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            // command, address, data: strobe low with latch lines set
            // busy dies drop address and data; caller waits for ready
            ST_WLOW: begin
               bus_ctl.ce_n <= 1'b0;
               bus_ctl.cle <= (cur_q.kind == REQ_CMD);
               bus_ctl.ale <= (cur_q.kind == REQ_ADDR);
               bus_ctl.read_strobe_n <= 1'b1;
               bus_ctl.we_n <= 1'b0;
               // upper lines zero; caller zeroes unused address bits; width
               io_out <= drive_val(cur_q, wide_bus);
               io_oe <= 1'b1;
               state_q <= ST_WHIGH;
            end
            // Rising write strobe latches the byte in the target
            ST_WHIGH: begin
               bus_ctl.we_n <= 1'b1;
               phase_q <= phase_q + 1'b1;
               if (phase_q == 2'(STROBE_HALF_CYC)) begin
                  phase_q <= 2'h0;
                  bus_ctl.cle <= 1'b0;
                  bus_ctl.ale <= 1'b0;
                  if (rst_sent_q && !init_done) begin
                     cnt_q <= '0;
                     state_q <= ST_RST_WAIT;
                  end else begin
                     req_ready <= 1'b1;
                     state_q <= ST_IDLE;
                  end
               end
            end
            // falling read strobe; caller orders status and read mode
            ST_RLOW: begin
               bus_ctl.ce_n <= 1'b0;
               bus_ctl.cle <= 1'b0;
               bus_ctl.ale <= 1'b0;
               io_oe <= 1'b0;
               bus_ctl.read_strobe_n <= 1'b0;
               state_q <= ST_RHIGH;
            end
            // read cycle is 150ns, so sample at the rising strobe
            // Data is still driven by the target at this edge; upper lines
            // are masked on narrow parts since they float there
            ST_RHIGH: begin
               bus_ctl.read_strobe_n <= 1'b1;
               rsp_data <= wide_bus ? io_in : {8'h00, io_in[7:0]};
               rsp_valid <= 1'b1;
               req_ready <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_PWR;
         endcase
      end
   end
endmodule : nand_host
`default_nettype wire

/* dv/nand_host_sva.sv */
// Port assertions for the host pin controller
`timescale 1ns/1ps
`default_nettype none
module nand_host_sva import nand_host_pkg::*; (
   input wire logic core_clk, // Clock
   input wire logic rst, // Async reset
   input wire logic wide_bus, // Sixteen-line device
   input wire logic init_done, // Power-up done
   input wire logic rsp_valid, // Read pulse
   input wire logic [15:0] rsp_data, // Read data
   input wire bus_ctl_t bus_ctl, // Control pins
   input wire logic [15:0] io_out, // Lines out
   input wire logic io_oe, // Lines driven
   input wire logic [15:0] io_in, // Lines in
   input wire logic rb_in // Ready/busy wire
);
   logic [15:0] up_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Cycles since reset, saturating so it never wraps
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) up_q <= 16'h0000;
      else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
   end
   property p_wp_init; !init_done |-> !bus_ctl.wp_n; endproperty
   a_wp_init: assert property (p_wp_init) else $error("protect raised early");
   property p_wp_quiet; $changed(bus_ctl.wp_n) |-> bus_ctl.ce_n && rb_in; endproperty
   a_wp_quiet: assert property (p_wp_quiet) else $error("protect moved mid use");
   property p_wp_settle; $changed(bus_ctl.wp_n) |=> bus_ctl.we_n [*2]; endproperty
   a_wp_settle: assert property (p_wp_settle) else $error("write too soon");
   property p_cmd_upper; !bus_ctl.ce_n && bus_ctl.cle && io_oe |-> io_out[15:8] == 8'h00;
   endproperty
   a_cmd_upper: assert property (p_cmd_upper) else $error("command upper not zero");
   property p_first; $fell(bus_ctl.we_n) && !init_done |-> bus_ctl.cle && io_out[7:0] == CMD_RESET;
   endproperty
   a_first: assert property (p_first) else $error("first command not reset");
   property p_pwr; $fell(bus_ctl.we_n) && !init_done |-> rb_in && up_q >= 16'(PWR_WAIT_CYC);
   endproperty
   a_pwr: assert property (p_pwr) else $error("reset sent too early");
   property p_read; $fell(bus_ctl.read_strobe_n) |=> bus_ctl.read_strobe_n && rsp_valid &&
      rsp_data == ($past(io_in) & (wide_bus ? 16'hFFFF : 16'h00FF)); endproperty
   a_read: assert property (p_read) else $error("read data not from strobe");
   property p_write; $fell(bus_ctl.we_n) |-> !bus_ctl.ce_n && io_oe ##1 bus_ctl.we_n && io_oe;
   endproperty
   a_write: assert property (p_write) else $error("write cycle malformed");
endmodule : nand_host_sva
bind nand_host nand_host_sva i_sva (.core_clk(core_clk), .rst(rst), .wide_bus(wide_bus),
   .init_done(init_done), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus_ctl(bus_ctl),
   .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb_in(rb_in));
`default_nettype wire

/* dv/nand_dev_model.sv */
// Behavioural flash target for the host bench
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model import nand_host_pkg::*; (
   input wire bus_ctl_t ctl, // Host control pins
   input wire logic [15:0] io_out, // Host bus lines
   output logic [15:0] io_in, // Lines seen by host
   output logic rb_low, // Open-drain pull-down
   output logic [7:0] first_cmd // First command taken
);
   logic [15:0] cache_q = 16'h0000;
   logic seen_q = 1'b0;
   initial begin
      io_in = 16'h5A5A;
      rb_low = 1'b0;
      first_cmd = 8'h00;
   end
   // latch on rising strobe, busy die ignores all
   always @(posedge ctl.we_n) if (!ctl.ce_n && !rb_low) begin
      if (ctl.cle && !seen_q) first_cmd = io_out[7:0];
      if (ctl.cle) seen_q = 1'b1;
      if (!ctl.cle && !ctl.ale) cache_q = io_out;
      if (ctl.cle && io_out[7:0] == CMD_RESET) begin
         rb_low = 1'b1;
         #2000 rb_low = 1'b0;
      end
   end
   // drive cache while strobe low, scrambled once released
   always @(ctl.read_strobe_n) io_in = (!ctl.read_strobe_n && !ctl.ce_n && !rb_low) ? cache_q : ~io_in;
endmodule : nand_dev_model
`default_nettype wire

/* dv/nand_host_tb.sv */
// Self-checking bench for the host pin controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module nand_host_tb;
   import nand_host_pkg::*;
   logic core_clk, rst, wide_bus, req_valid, wp_enable_req, req_ready, rsp_valid;
   logic init_done, io_oe, rb_low;
   logic [15:0] rsp_data, io_out, io_in, d, e_v;
   logic [7:0] first_cmd;
   host_req_t req;
   bus_ctl_t bus_ctl;
   logic [15:0] exp_q[$];
   int checks = 0;
   int mismatches = 0;
   wire rb_in = ~rb_low;
   nand_host i_dut (.core_clk(core_clk), .rst(rst), .wide_bus(wide_bus), .use_rb(1'b1),
      .req_valid(req_valid), .req(req), .wp_enable_req(wp_enable_req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done), .bus_ctl(bus_ctl),
      .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb_in(rb_in));
   nand_dev_model i_dev (.ctl(bus_ctl), .io_out(io_out), .io_in(io_in), .rb_low(rb_low),
      .first_cmd(first_cmd));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // Request held until the edge that takes it
   task automatic xfer(input req_kind_t k, input logic [15:0] v);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req <= '{kind: k, data: v};
      do @(posedge core_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
   endtask : xfer
   // Oldest noted read result against each pulse
   always @(posedge core_clk) if (rsp_valid === 1'b1) begin
      e_v = exp_q.size() ? exp_q.pop_front() : 16'hDEAD;
      `CHK("rsp_data", e_v, rsp_data)
   end
   initial begin
      #1_000_000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      {rst, wide_bus, req_valid, req, wp_enable_req} = {3'b100, 19'h0, 1'b0};
      void'($urandom(32802));
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      do @(posedge core_clk); while (init_done !== 1'b1);
      `CHK("first_cmd", CMD_RESET, first_cmd)
      for (int w = 0; w < 2; w++) begin
         wide_bus <= w[0];
         for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            // Random upper byte on commands must never reach the lines
            xfer(REQ_CMD, {d[15:8], 8'h80});
            xfer(REQ_ADDR, {8'h00, d[7:0]}); // unused address bits low
            xfer(REQ_WDATA, d);
            if (i == 3) xfer(REQ_CMD, {8'h00, CMD_STATUS_ENH});
            if (i == 3) xfer(REQ_CMD, {8'h00, CMD_READ_MODE});
            exp_q.push_back(w ? d : {8'h00, d[7:0]});
            xfer(REQ_RDATA, 16'h0000);
         end
         wp_enable_req <= ~w[0];
         repeat (12) @(posedge core_clk);
         `CHK("wp_n", ~w[0], bus_ctl.wp_n)
      end
      repeat (8) @(posedge core_clk);
      `CHK("pending reads", 0, exp_q.size())
      tally_and_finish();
   end
endmodule : nand_host_tb
`default_nettype wire
